// File: dtpm_defs.vh
// Purpose: shared constants for the training pattern block
// Assumes: one 10 MHz clock, device side of the memory link
// Notes:   offsets are byte addresses on the register bus
`ifndef DTPM_DEFS_VH
`define DTPM_DEFS_VH

// clock period in ns
`define DTPM_CLK_NS        100
// mode command delay, in memory clock cycles
`define DTPM_MOD_CK        12
`define DTPM_MOD_W         4
`define DTPM_MOD_LAST      4'h0_00B

// mode register select codes (bank address on a mode command)
`define DTPM_MR_ZERO       2'h0
`define DTPM_MR_ONE        2'h1
`define DTPM_MR_THREE      2'h3

// field positions in the address word of mode and read commands
`define DTPM_A_BL_HI       1
`define DTPM_A_BL_LO       0
`define DTPM_A_LOC_HI      1
`define DTPM_A_LOC_LO      0
`define DTPM_A_NIBBLE      2
`define DTPM_A_MPR         2
`define DTPM_A_WL          7
`define DTPM_A_CHOP        12

// burst length field codes
`define DTPM_BL_EIGHT      2'h0
`define DTPM_BL_OTF        2'h1
`define DTPM_BL_FOUR       2'h2

// pattern locations
`define DTPM_LOC_CALIB     2'h0
`define DTPM_CALIB_PAT     8'hA_A
`define DTPM_RSVD_PAT      8'h0_0

// beats per burst, last beat index
`define DTPM_LAST_BL8      3'h7
`define DTPM_LAST_BC4      3'h3

// read latency pipeline depth
`define DTPM_RL_DEPTH      32
`define DTPM_RL_W          5

// register map
`define DTPM_REG_CTRL      4'h0
`define DTPM_REG_LAT       4'h4
`define DTPM_REG_STAT      4'h8
`define DTPM_CTRL_COPY     0
`define DTPM_LAT_AL_HI     4
`define DTPM_LAT_CL_LO     8
`define DTPM_LAT_CL_HI     12
`define DTPM_AL_RST        5'h06
`define DTPM_CL_RST        5'h00

`endif

// File: dtpm_pattern.v
// Purpose: selects one pattern bit for a given location and beat
// Assumes: location and burst order index already settled
// Notes:   purely combinational; the caller registers the result
`timescale 1ns/100ps
`include "dtpm_defs.vh"

module dtpm_pattern (
    input  wire [1:0] loc_in,    // pattern location
    input  wire [2:0] order_in,  // burst order bit index
    output wire       bit_out    // pattern bit for this beat
);
    wire [7:0] word;  // selected location contents

    // location 00 is the calibration pattern, others are reserved
    assign word = (loc_in == `DTPM_LOC_CALIB) ? `DTPM_CALIB_PAT : `DTPM_RSVD_PAT;
    // order bit 0 is the lsb, order bit 7 the msb
    assign bit_out = word[order_in];
endmodule // dtpm_pattern

// File: dtpm_core.v
// Purpose: device-side write leveling exit and pattern readout logic
// Assumes: commands arrive decoded and synchronous, one per cycle
// Notes:   one beat per clock; a burst is 8 or 4 beats on dq_out
//
// Functional notes
// - leveling active while mode reg one bit7
// - data undefined until mode delay after exit
// - reads served from pattern register location
// - read with autoprecharge acts as read
// - reset works during pattern mode
// - bit2 clear gives normal array access
// - lane line zero carries pattern, others copy/zero
// - column bit2 selects burst order nibble on chopped bursts
// - bit12 chops on fly when enabled
// - order bit0 lsb, bit7 msb
// - pattern data at added plus column latency (dq_out here starts one cycle later)
// - location zero returns alternating pattern
`timescale 1ns/100ps
`include "dtpm_defs.vh"

module dtpm_core (
    input  wire        ref_clk_in,        // system clock
    input  wire        sys_rst_in,        // async reset, high
    input  wire        dev_rst_n_in,      // device reset pin, low
    // decoded command inputs
    input  wire        cmd_mrs_in,        // mode register set
    input  wire        cmd_read_in,       // read
    input  wire        cmd_read_ap_in,    // read with autoprecharge
    input  wire        cmd_write_in,      // write
    input  wire [1:0]  bank_in,           // bank address
    input  wire [14:0] addr_in,           // address bus
    input  wire        strobe_active_in,  // controller drives strobe pair
    // array side
    output reg         array_read_out,    // normal read request pulse
    output reg         array_write_out,   // normal write request pulse
    output reg         precharge_out,     // autoprecharge request pulse
    // data lanes
    output reg  [15:0] dq_out,            // data lines, two lanes
    output reg         dq_oe_out,         // data lines driven
    output reg         dq_undef_out,      // data lines undefined
    output reg         level_mode_out,    // write leveling active
    output reg         pattern_mode_out,  // pattern readout active
    // classic wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o
);
    // mode state
    reg [1:0]  burst_len;      // mode reg zero burst field
    reg [1:0]  pattern_location; // mode reg three location
    reg        copy_all;       // upper lines copy line zero
    reg [4:0]  added_latency;  // software set
    reg [4:0]  column_latency; // software set
    reg [`DTPM_MOD_W-1:0] mod_cnt; // mode delay counter
    reg        mod_run;        // counting after leveling exit
    // latency pipeline, one entry per cycle
    reg [`DTPM_RL_DEPTH-1:0] pl_vld;   // read launched
    reg [`DTPM_RL_DEPTH-1:0] pl_chop;  // chopped burst
    reg [`DTPM_RL_DEPTH-1:0] pl_nib;   // upper nibble first
    // burst engine
    reg        bst_run;        // burst in progress
    reg [2:0]  bst_beat;       // beat counter
    reg [2:0]  bst_last;       // last beat index
    reg        bst_nib;        // nibble start
    wire [2:0] order;          // burst order index
    wire       pat_bit;        // selected pattern bit
    wire [5:0] rl_sum;         // added plus column latency
    wire [`DTPM_RL_W-1:0] rl_idx; // pipeline tap
    wire       rst_dev;        // device reset request
    wire       is_read;        // any read command
    wire       chop_now;       // this read is chopped
    wire       launch;         // burst starts this cycle
    wire       wb_req;         // bus request awaiting ack
    reg        next_undef;     // next undefined flag

    assign rst_dev = ~dev_rst_n_in;
    assign is_read = cmd_read_in | cmd_read_ap_in;
    assign rl_sum  = {1'b0, added_latency} + {1'b0, column_latency};
    assign rl_idx  = rl_sum[`DTPM_RL_W-1:0] - 5'h0_001;
    // chop from fixed field or from bit12 when on the fly
    assign chop_now = (burst_len == `DTPM_BL_FOUR) |
                      ((burst_len == `DTPM_BL_OTF) & ~addr_in[`DTPM_A_CHOP]);
    assign launch  = pl_vld[rl_idx];
    assign order   = bst_beat + {bst_nib, 2'b00};
    assign wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    // pattern lookup for the current beat
    dtpm_pattern u_pat (
        .loc_in   (pattern_location),
        .order_in (order),
        .bit_out  (pat_bit)
    );

    // mode register capture; device reset clears modes
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            burst_len        <= `DTPM_BL_EIGHT;
            level_mode_out   <= 1'b0;
            pattern_mode_out <= 1'b0;
            pattern_location <= `DTPM_LOC_CALIB;
        end else if (rst_dev) begin
            burst_len        <= `DTPM_BL_EIGHT;
            level_mode_out   <= 1'b0;
            pattern_mode_out <= 1'b0;
            pattern_location <= `DTPM_LOC_CALIB;
        end else if (cmd_mrs_in) begin
            case (bank_in)
                `DTPM_MR_ZERO: begin
                    burst_len <= addr_in[`DTPM_A_BL_HI:`DTPM_A_BL_LO];
                end
                `DTPM_MR_ONE: begin
                    level_mode_out <= addr_in[`DTPM_A_WL];
                end
                `DTPM_MR_THREE: begin
                    pattern_mode_out <= addr_in[`DTPM_A_MPR];
                    pattern_location <= addr_in[`DTPM_A_LOC_HI:`DTPM_A_LOC_LO];
                end
                default: begin
                    burst_len <= burst_len;
                end
            endcase
        end
    end

    // undefined data after strobes stop, until mode delay elapses
    always @* begin
        next_undef = dq_undef_out;
        if (mod_run & (mod_cnt == `DTPM_MOD_LAST)) begin
            next_undef = 1'b0;
        end
        // set wins over the end of the count
        if (level_mode_out & ~strobe_active_in) begin
            next_undef = 1'b1;
        end
    end

    // mode delay counter started by the leveling exit command
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            mod_run      <= 1'b0;
            mod_cnt      <= {`DTPM_MOD_W{1'b0}};
            dq_undef_out <= 1'b0;
        end else if (rst_dev) begin
            mod_run      <= 1'b0;
            mod_cnt      <= {`DTPM_MOD_W{1'b0}};
            dq_undef_out <= 1'b0;
        end else begin
            dq_undef_out <= next_undef;
            if (cmd_mrs_in & (bank_in == `DTPM_MR_ONE) & level_mode_out & ~addr_in[`DTPM_A_WL]) begin
                mod_run <= 1'b1;
                mod_cnt <= {`DTPM_MOD_W{1'b0}};
            end else if (mod_run) begin
                mod_cnt <= mod_cnt + 4'h0_001;
                if (mod_cnt == `DTPM_MOD_LAST) begin
                    mod_run <= 1'b0;
                end
            end
        end
    end

    // array requests only outside pattern mode
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            array_read_out  <= 1'b0;
            array_write_out <= 1'b0;
            precharge_out   <= 1'b0;
        end else begin
            array_read_out  <= is_read & ~pattern_mode_out & ~rst_dev;
            array_write_out <= cmd_write_in & ~pattern_mode_out & ~rst_dev;
            // autoprecharge dropped in pattern mode
            precharge_out   <= cmd_read_ap_in & ~pattern_mode_out & ~rst_dev;
        end
    end

    // latency pipeline, one stage per cycle
    genvar g;
    generate
        for (g = 0; g < `DTPM_RL_DEPTH; g = g + 1) begin : g_pl
            localparam PREV = (g > 0) ? g - 1 : 0; // feeding stage, unused at stage zero
            always @(posedge ref_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    pl_vld[g]  <= 1'b0;
                    pl_chop[g] <= 1'b0;
                    pl_nib[g]  <= 1'b0;
                end else if (rst_dev) begin
                    pl_vld[g]  <= 1'b0;
                    pl_chop[g] <= 1'b0;
                    pl_nib[g]  <= 1'b0;
                end else if (g == 0) begin
                    // pattern read enters; bank and other columns ignored
                    pl_vld[g]  <= is_read & pattern_mode_out;
                    pl_chop[g] <= chop_now;
                    pl_nib[g]  <= chop_now & addr_in[`DTPM_A_NIBBLE];
                end else begin
                    pl_vld[g]  <= pl_vld[PREV];
                    pl_chop[g] <= pl_chop[PREV];
                    pl_nib[g]  <= pl_nib[PREV];
                end
            end
        end
    endgenerate

    // burst engine; a new launch restarts the beat count
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bst_run  <= 1'b0;
            bst_beat <= 3'h0;
            bst_last <= `DTPM_LAST_BL8;
            bst_nib  <= 1'b0;
        end else if (rst_dev) begin
            bst_run  <= 1'b0;
            bst_beat <= 3'h0;
        end else if (launch) begin
            bst_run  <= 1'b1;
            bst_beat <= 3'h0;
            bst_last <= pl_chop[rl_idx] ? `DTPM_LAST_BC4 : `DTPM_LAST_BL8;
            bst_nib  <= pl_nib[rl_idx];
        end else if (bst_run) begin
            bst_beat <= bst_beat + 3'h1;
            if (bst_beat == bst_last) begin
                bst_run <= 1'b0;
            end
        end
    end

    // data lanes: line zero of each lane carries the bit
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            dq_out    <= 16'h0_000;
            dq_oe_out <= 1'b0;
        end else if (bst_run & ~rst_dev) begin
            dq_oe_out <= 1'b1;
            dq_out    <= {{7{copy_all & pat_bit}}, pat_bit,
                          {7{copy_all & pat_bit}}, pat_bit};
        end else begin
            dq_oe_out <= 1'b0;
            dq_out    <= 16'h0_000;
        end
    end

    // wishbone slave: ack one cycle after request, unmapped reads zero
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h0000_0000;
            copy_all       <= 1'b1;
            added_latency  <= `DTPM_AL_RST;
            column_latency <= `DTPM_CL_RST;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req & wb_we_i) begin
                case (wb_adr_i)
                    `DTPM_REG_CTRL: begin
                        if (wb_sel_i[0]) begin
                            copy_all <= wb_dat_i[`DTPM_CTRL_COPY];
                        end
                    end
                    `DTPM_REG_LAT: begin
                        if (wb_sel_i[0]) begin
                            added_latency <= wb_dat_i[`DTPM_LAT_AL_HI:0];
                        end
                        if (wb_sel_i[1]) begin
                            column_latency <= wb_dat_i[`DTPM_LAT_CL_HI:`DTPM_LAT_CL_LO];
                        end
                    end
                    default: begin
                        copy_all <= copy_all;
                    end
                endcase
            end else if (wb_req) begin
                case (wb_adr_i)
                    `DTPM_REG_CTRL: begin
                        wb_dat_o <= {31'h0000_0000, copy_all};
                    end
                    `DTPM_REG_LAT: begin
                        wb_dat_o <= {19'h0_0000, column_latency, 3'h0, added_latency};
                    end
                    `DTPM_REG_STAT: begin
                        wb_dat_o <= {24'h00_0000, burst_len, pattern_location, bst_run,
                                     dq_undef_out, pattern_mode_out, level_mode_out};
                    end
                    default: begin
                        wb_dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end
endmodule // dtpm_core

// File: dtpm_core_properties.sv
// Purpose: port-level checks of the training pattern block
// Assumes: one clock domain, sys_rst_in asynchronous and high
// Notes:   bound into every dtpm_core instance below
`timescale 1ns/100ps
module dtpm_properties (
    input wire logic        ref_clk_in,       // system clock
    input wire logic        sys_rst_in,       // async reset
    input wire logic        dev_rst_n_in,     // device reset, low
    input wire logic        cmd_mrs_in,       // mode command
    input wire logic        cmd_read_in,      // read
    input wire logic        cmd_read_ap_in,   // read with precharge
    input wire logic        cmd_write_in,     // write
    input wire logic [1:0]  bank_in,          // bank / mode reg select
    input wire logic [14:0] addr_in,          // address
    input wire logic        strobe_active_in, // strobes driven
    input wire logic        array_read_out,   // array read pulse
    input wire logic        array_write_out,  // array write pulse
    input wire logic        precharge_out,    // precharge pulse
    input wire logic [15:0] dq_out,           // data lines
    input wire logic        dq_oe_out,        // data driven
    input wire logic        dq_undef_out,     // data undefined
    input wire logic        level_mode_out,   // leveling active
    input wire logic        pattern_mode_out, // pattern mode active
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // mode command to one mode register, device out of reset
    sequence mrs_to(logic [1:0] sel);
        cmd_mrs_in && bank_in == sel && dev_rst_n_in;
    endsequence
    // leveling exit command while data already undefined
    sequence lvl_exit;
        mrs_to(2'h1) ##0 (!addr_in[7] && level_mode_out && dq_undef_out);
    endsequence
    level_mode_a: assert property (mrs_to(2'h1) |=> level_mode_out == $past(addr_in[7]))
        else $error("leveling mode does not follow mode reg one bit 7");
    pattern_mode_a: assert property (mrs_to(2'h3) |=> pattern_mode_out == $past(addr_in[2]))
        else $error("pattern mode does not follow mode reg three bit 2");
    normal_read_a: assert property (cmd_read_in && !pattern_mode_out && dev_rst_n_in |=> array_read_out)
        else $error("normal read did not reach the array");
    pattern_read_a: assert property ((cmd_read_in || cmd_read_ap_in) && pattern_mode_out
        |=> !array_read_out && !precharge_out)
        else $error("pattern read reached array or precharged");
    write_drop_a: assert property (cmd_write_in && pattern_mode_out |=> !array_write_out)
        else $error("write reached array in pattern mode");
    dev_reset_a: assert property (!dev_rst_n_in |-> ##[1:2] (!pattern_mode_out && !dq_oe_out))
        else $error("device reset did not clear pattern mode");
    lane_copy_a: assert property (dq_oe_out |-> dq_out[0] == dq_out[8]
        && (dq_out[7:1] == {7{dq_out[0]}} || dq_out[7:1] == 7'h00)
        && (dq_out[15:9] == {7{dq_out[8]}} || dq_out[15:9] == 7'h00))
        else $error("lane lines neither copy nor zero");
    undef_start_a: assert property (level_mode_out && $fell(strobe_active_in) |=> dq_undef_out)
        else $error("data not undefined after strobes stop");
    undef_hold_a: assert property (lvl_exit |=> dq_undef_out [*8])
        else $error("data defined too early after leveling exit");
    undef_end_a: assert property (lvl_exit |-> ##[12:14] !dq_undef_out)
        else $error("data still undefined after mode delay");
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged");
    wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule // dtpm_properties

bind dtpm_core dtpm_properties u_props (.ref_clk_in, .sys_rst_in, .dev_rst_n_in, .cmd_mrs_in, .cmd_read_in,
    .cmd_read_ap_in, .cmd_write_in, .bank_in, .addr_in, .strobe_active_in, .array_read_out, .array_write_out,
    .precharge_out, .dq_out, .dq_oe_out, .dq_undef_out, .level_mode_out, .pattern_mode_out, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o);

// File: dtpm_ctl_model.sv
// Purpose: memory controller model issuing training commands
// Assumes: commands change right after a rising edge
// Notes:   spacing between commands kept by an idle counter
`timescale 1ns/100ps
module dtpm_ctl_model #(
    parameter MOD_CK = 12  // mode command delay
) (
    input  wire logic        ref_clk_in,        // system clock
    output logic             cmd_mrs_out,       // mode command
    output logic             cmd_read_out,      // read
    output logic             cmd_read_ap_out,   // read with precharge
    output logic             cmd_write_out,     // write
    output logic [1:0]       bank_out,          // bank address
    output logic [14:0]      addr_out,          // address
    output logic             strobe_out,        // strobes driven
    output logic             term_ctrl_pin_out  // termination pin
);
    integer idle = 0;   // cycles since last command
    integer need = 0;   // spacing owed before next one
    logic   in_pat = 0; // pattern mode tracking
    initial begin
        {cmd_mrs_out, cmd_read_out, cmd_read_ap_out, cmd_write_out, strobe_out} = 5'h00;
        {bank_out, addr_out} = 17'h0_0000;
        term_ctrl_pin_out = 1'b0; // held low
    end
    // count idle cycles, restart on any command
    always @(posedge ref_clk_in) begin
        idle <= (cmd_mrs_out | cmd_read_out | cmd_read_ap_out | cmd_write_out) ? 0 : idle + 1;
    end
    // kind: 0 mode, 1 read, 2 read ap, 3 write; bad lets a refused write through
    task issue(input logic [1:0] kind, input logic [1:0] b, input logic [14:0] a, input logic bad);
        begin
            @(posedge ref_clk_in);
            while (idle < need) @(posedge ref_clk_in);
            if (bad || !(in_pat && kind == 2'h3)) begin
                bank_out <= b;
                addr_out <= a;
                cmd_mrs_out <= (kind == 2'h0);
                cmd_read_out <= (kind == 2'h1);
                cmd_read_ap_out <= (kind == 2'h2);
                cmd_write_out <= (kind == 2'h3);
                @(posedge ref_clk_in);
                {cmd_mrs_out, cmd_read_out, cmd_read_ap_out, cmd_write_out} <= 4'h0;
                bank_out <= ~b; // released lines lose their value
                addr_out <= ~a;
                need = (kind == 2'h0) ? MOD_CK : 8;
                if (kind == 2'h0 && b == 2'h3) in_pat = a[2];
            end
        end
    endtask
    // leveling exit: drive strobes 4 cycles, stop them, then exit command
    task level_exit;
        begin
            @(posedge ref_clk_in);
            strobe_out <= 1'b1;
            repeat (4) @(posedge ref_clk_in);
            strobe_out <= 1'b0;
            repeat (3) @(posedge ref_clk_in);
            issue(2'h0, 2'h1, 15'h0000, 1'b0);
        end
    endtask
endmodule // dtpm_ctl_model

// File: dtpm_core_tb.sv
// Purpose: self-checking bench of the training pattern block
// Assumes: 10 MHz clock, latency programmed to AL 2 plus CL 5
// Notes:   commands come from the controller model
`timescale 1ns/100ps
module dtpm_core_tb;
    logic        ref_clk_in, sys_rst_in, dev_rst_n_in;     // clock and resets
    logic        wb_cyc_i, wb_stb_i, wb_we_i;              // bus strobes
    logic [3:0]  wb_adr_i;                                 // bus address
    logic [31:0] wb_dat_i, rd;                             // write and read data
    wire  [31:0] wb_dat_o;                                 // bus read data
    wire         wb_ack_o, mode_reg_set_cmd, rdc, read_autoprecharge_cmd, wrc, stb, term;  // handshake, commands
    wire  [1:0]  bank;                                     // bank select
    wire  [14:0] addr;                                     // address
    wire         a_rd, a_wr, pre, oe, undef, lvl, pat;     // status outputs
    wire  [15:0] dq_out;                                   // data lines
    integer      fails = 0, comparisons = 0, n_rd = 0, n_wr = 0, n_pre = 0, i; // counts
    dtpm_ctl_model u_ctl (.ref_clk_in(ref_clk_in), .cmd_mrs_out(mode_reg_set_cmd), .cmd_read_out(rdc),
        .cmd_read_ap_out(read_autoprecharge_cmd), .cmd_write_out(wrc), .bank_out(bank), .addr_out(addr),
        .strobe_out(stb), .term_ctrl_pin_out(term));
    dtpm_core u_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .dev_rst_n_in(dev_rst_n_in),
        .cmd_mrs_in(mode_reg_set_cmd), .cmd_read_in(rdc), .cmd_read_ap_in(read_autoprecharge_cmd), .cmd_write_in(wrc), .bank_in(bank),
        .addr_in(addr), .strobe_active_in(stb), .array_read_out(a_rd), .array_write_out(a_wr),
        .precharge_out(pre), .dq_out(dq_out), .dq_oe_out(oe), .dq_undef_out(undef), .level_mode_out(lvl),
        .pattern_mode_out(pat), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    // clock
    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end
    // array side pulse counters
    always @(posedge ref_clk_in) begin
        n_rd += (a_rd === 1'b1);
        n_wr += (a_wr === 1'b1);
        n_pre += (pre === 1'b1);
    end
    task cmp_bit(input logic got, input logic exp);
        begin
            comparisons++;
            if (got !== exp) begin
                fails++;
                $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
            end
        end
    endtask
    task cmp_word(input logic [31:0] got, input logic [31:0] exp);
        begin
            comparisons++;
            if (got !== exp) begin
                fails++;
                $display("[FAIL] %0t value %h expected %h", $time, got, exp);
            end
        end
    endtask
    // one classic bus cycle, held until ack
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        begin
            @(posedge ref_clk_in);
            {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, d};
            // wait for ack; only the watchdog ends a hang
            do @(posedge ref_clk_in);
            while (wb_ack_o !== 1'b1);
            rd = wb_dat_o;
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask
    // pattern read: latency, each beat, then lines released
    task burst(input logic [1:0] kind, input logic [14:0] a, input logic [1:0] loc, input integer n, input logic cp);
        integer k, j;
        logic b;
        begin
            u_ctl.issue(kind, 2'h2, a, 1'b0);
            k = 0;
            while (oe !== 1'b1 && k < 40) begin
                @(negedge ref_clk_in);
                k++;
            end
            cmp_word(k, 32'h0000_0009);
            for (j = 0; j < n; j++) begin
                b = (loc == 2'h0) && j[0];
                cmp_word({16'h0000, dq_out}, {16'h0000, cp ? {16{b}} : {7'h00, b, 7'h00, b}});
                @(negedge ref_clk_in);
            end
            cmp_bit(oe, 1'b0);
        end
    endtask
    task t_regs;
        begin
            wb(1'b0, 4'h0, 32'h0000_0000);
            cmp_word(rd, 32'h0000_0001);
            wb(1'b1, 4'h4, 32'h0000_0502);
            wb(1'b0, 4'h4, 32'h0000_0000);
            cmp_word(rd, 32'h0000_0502);
            wb(1'b0, 4'hC, 32'h0000_0000);
            cmp_word(rd, 32'h0000_0000);
        end
    endtask
    task t_level;
        integer n;
        begin
            u_ctl.issue(2'h0, 2'h1, 15'h0080, 1'b0);
            @(negedge ref_clk_in) cmp_bit(lvl, 1'b1);
            u_ctl.level_exit;
            n = 0;
            repeat (20) @(negedge ref_clk_in) n += (undef === 1'b1);
            cmp_word(n, 32'h0000_000C);
            cmp_bit(lvl, 1'b0);
        end
    endtask
    task t_pattern;
        begin
            u_ctl.issue(2'h0, 2'h0, 15'h0001, 1'b0);
            u_ctl.issue(2'h0, 2'h3, 15'h0004, 1'b0);
            @(negedge ref_clk_in) cmp_bit(pat, 1'b1);
            burst(2'h1, 15'h7FF8, 2'h0, 8, 1'b1);
            burst(2'h2, 15'h0400, 2'h0, 4, 1'b1);
            burst(2'h1, 15'h0004, 2'h0, 4, 1'b1);
            u_ctl.issue(2'h3, 2'h0, 15'h0000, 1'b1);
            wb(1'b1, 4'h0, 32'h0000_0000);
            burst(2'h1, 15'h1000, 2'h0, 8, 1'b0);
            wb(1'b1, 4'h0, 32'h0000_0001);
            for (i = 1; i < 4; i++) begin
                u_ctl.issue(2'h0, 2'h3, 15'h0004 | i[14:0], 1'b0);
                burst(2'h1, 15'h1000, i[1:0], 8, 1'b1);
            end
            u_ctl.issue(2'h0, 2'h0, 15'h0002, 1'b0);
            burst(2'h1, 15'h1004, 2'h3, 4, 1'b1);
            cmp_word(n_rd + n_wr + n_pre, 32'h0000_0000);
        end
    endtask
    task t_normal;
        begin
            u_ctl.issue(2'h0, 2'h3, 15'h0003, 1'b0);
            u_ctl.issue(2'h1, 2'h0, 15'h0000, 1'b0);
            u_ctl.issue(2'h2, 2'h0, 15'h0400, 1'b0);
            u_ctl.issue(2'h3, 2'h0, 15'h0000, 1'b0);
            repeat (3) @(negedge ref_clk_in);
            cmp_word({n_rd[7:0], n_wr[7:0], n_pre[7:0]}, 32'h0002_0101);
        end
    endtask
    task t_devrst;
        begin
            u_ctl.issue(2'h0, 2'h3, 15'h0004, 1'b0);
            @(negedge ref_clk_in) cmp_bit(pat, 1'b1);
            @(posedge ref_clk_in) dev_rst_n_in <= 1'b0;
            repeat (2) @(posedge ref_clk_in);
            dev_rst_n_in <= 1'b1;
            @(negedge ref_clk_in) cmp_bit(pat, 1'b0);
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    // watchdog
    initial begin
        #(5000 * 100);
        fails++;
        report_and_stop;
    end
    // main sequence
    initial begin
        {sys_rst_in, dev_rst_n_in, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h18;
        {wb_adr_i, wb_dat_i} = 36'h0_0000_0000;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        t_regs;
        t_level;
        t_pattern;
        t_normal;
        t_devrst;
        report_and_stop;
    end
endmodule // dtpm_core_tb
